// >>> design/sar_adc_cfg.svh
// constants for the converter control and result readout block
// assumes a 20 MHz system clock and a host that drives the shift clock
//
// Overview of operation
// [R1] interface select high picks serial port
// [R2] serial mode floats unused parallel data pins
// [R3] format low inverts result msb everywhere
// [R4] swap low gives natural bit order
// [R5] swap high exchanges upper and lower bytes
// [R6] parallel pins carry matching result bits
// [R7] serial mode: bit9 chain in, 10 out, 11 clock
// [R8] chain input reaches serial output 16 clocks later
// [R9] msb first, change on rise, host samples fall
// [R10] busy high from start until conversion done
// [R11] host may use busy fall as ready
// [R12] outputs enabled only with select and read low
// [R13] chip select gates the shift clock
// [R14] reset aborts conversion and floats data pins
// [R15] power down ignores conversion start requests
// [R16] host reads result before powering down
// [R17] convert start fall holds sample, starts conversion
// [R18] start edges accepted regardless of chip select
// [R19] conversion end prepares sixteen bit output code
// [R20] select or read high keeps outputs floating
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
// =====================================================================
// timing
`define SYS_CLK_PERIOD_NS 50
`define CONV_TIME_NS 600
// longest time, so the division rounds down
`define CONV_CYCLES (`CONV_TIME_NS / `SYS_CLK_PERIOD_NS)
// =====================================================================
// data pin layout
`define RESULT_WIDTH 16
`define CHAIN_IN_BIT 9
`define SERIAL_OUT_BIT 10
`define SHIFT_CLK_BIT 11
`define SERIAL_OE_MASK 16'h0400
`define RESULT_RESET 16'h0000
// synchroniser reset: strobes and start high, power down low
`define CTL_RESET 7'h07
`define CHAIN_START_COUNT 5'h11
`endif

// >>> design/sar_adc_pkg.sv
// types shared by the converter control and readout logic
// assumes the constants header is included by the design file
package sar_adc_pkg;
	// =================================================================
	// conversion sequencer, gray coded along idle, convert, latch
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_LATCH = 2'b11
	} conv_state_e;
	// =================================================================
	// control pins from the host, all level inputs
	typedef struct packed {
		logic interfaceSelect;
		logic codeFormatSelect;
		logic byteOrderSwap;
		logic powerDownRequest;
		logic convertStartN;
		logic chipSelectN;
		logic readN;
	} pin_ctl_s;
	typedef logic [15:0] result_t;
endpackage : sar_adc_pkg

// >>> design/sar_adc_readout.sv
// conversion sequencer and result readout of a 16-bit sar converter
// assumes control pins arrive asynchronously and the host drives the
// shift clock only while chip select is low
`include "sar_adc_cfg.svh"
`timescale 1ns/1ps
module sar_adc_readout (
	// system clock and synchronous reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// host shift clock, the serial link domain
	input wire logic shiftClk,
	// control pins
	input wire sar_adc_pkg::pin_ctl_s ctlPins,
	// code settled in the comparator array
	input wire sar_adc_pkg::result_t sarCode,
	// shared data pins, three signals each
	input wire logic [15:0] dataIn,
	output logic [15:0] dataOut,
	output logic [15:0] dataOe,
	// status
	output logic busy,
	output logic sampleHold,
	output logic poweredDown
);
	import sar_adc_pkg::*;

	// =================================================================
	// helpers
	// msb inverted when two's complement is chosen
	function automatic result_t formatCode(input result_t code,
		input logic offsetBinary);
		formatCode = {code[15] ^ ~offsetBinary, code[14:0]};
	endfunction : formatCode

	// upper and lower bytes exchanged
	function automatic result_t swapBytes(input result_t code);
		swapBytes = {code[7:0], code[15:8]};
	endfunction : swapBytes

	// =================================================================
	// pin synchronisers
	pin_ctl_s ctlMeta_r; // first stage, read only by the second
	pin_ctl_s ctlSync_r; // usable copy of the pins
	logic startPrevN_r; // previous convert start level

	// two flops on every asynchronous control pin
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			// all ones would fake a power down after every reset
			ctlMeta_r <= `CTL_RESET;
			ctlSync_r <= `CTL_RESET;
			startPrevN_r <= 1'b1;
		end else begin
			ctlMeta_r <= ctlPins;
			ctlSync_r <= ctlMeta_r;
			startPrevN_r <= ctlSync_r.convertStartN;
		end
	end

	// =================================================================
	// decoded control
	wire serialMode = ctlSync_r.interfaceSelect; // R1
	wire offsetBinary = ctlSync_r.codeFormatSelect;
	wire swapOrder = ctlSync_r.byteOrderSwap;
	wire pdActive = ctlSync_r.powerDownRequest;
	// both strobes low enable the drivers
	wire readEnable = ~ctlSync_r.chipSelectN & ~ctlSync_r.readN; // R12
	// chip select is not looked at here
	wire startFall = startPrevN_r & ~ctlSync_r.convertStartN; // R17 R18

	// =================================================================
	// conversion sequencer
	conv_state_e state_r; // sequencer state
	conv_state_e state_nxt;
	logic [3:0] convCount_r; // cycles spent converting
	logic [3:0] convCount_nxt;
	result_t result_r; // latched conversion result
	logic busy_r;
	logic hold_r;
	logic pd_r;

	// starts while powered down or converting are dropped
	wire startAccept = startFall & ~pdActive & (state_r == ST_IDLE); // R15
	wire convLast = convCount_r == 4'(`CONV_CYCLES - 1);

	// next state; the internal timer sets the conversion length
	always_comb begin
		state_nxt = state_r;
		convCount_nxt = convCount_r;
		unique case (state_r)
			ST_IDLE: begin
				convCount_nxt = 4'h0;
				if (startAccept) begin
					state_nxt = ST_CONV; // R17
				end
			end
			ST_CONV: begin
				convCount_nxt = convCount_r + 4'h1;
				if (convLast) begin
					state_nxt = ST_LATCH;
				end
			end
			ST_LATCH: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				// a stray code returns to idle
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// reset aborts any conversion in flight
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE; // R14
			convCount_r <= 4'h0;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			convCount_r <= convCount_nxt;
			busy_r <= state_nxt != ST_IDLE; // R10
			hold_r <= state_nxt == ST_CONV; // R17
			pd_r <= pdActive; // R15
		end
	end

	// result is taken as the latch state begins, so the pin word is
	// already updated on the edge at which busy falls
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			result_r <= `RESULT_RESET;
		end else if (state_r == ST_CONV && convLast) begin
			result_r <= sarCode; // R19
		end
	end

	// =================================================================
	// output word and driver enables
	wire result_t fmtWord = formatCode(result_r, offsetBinary); // R3
	// swap applies to the parallel bus only
	wire result_t parWord = swapOrder ? swapBytes(fmtWord) : fmtWord; // R4 R5 R6
	// serial mode drives only the serial output pin
	wire [15:0] oeMask = serialMode ? `SERIAL_OE_MASK : 16'hFFFF; // R2 R7
	wire [15:0] oe_nxt = readEnable ? oeMask : 16'h0000; // R12 R20

	result_t parOut_r;
	result_t serialWord_r; // word the link domain loads
	logic [15:0] oe_r;
	logic serialSel_r; // pad mux select for the serial bit

	// all drivers float in reset and whenever deselected
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			parOut_r <= `RESULT_RESET;
			serialWord_r <= `RESULT_RESET;
			oe_r <= 16'h0000; // R14
			serialSel_r <= 1'b0;
		end else begin
			parOut_r <= parWord;
			serialWord_r <= fmtWord; // R3
			oe_r <= oe_nxt; // R20
			serialSel_r <= serialMode; // R7
		end
	end

	// =================================================================
	// serial link domain
	logic [4:0] bitCount_r; // edges seen in this frame, saturating
	result_t shiftReg_r; // remaining bits, chain input behind them
	logic serialOut_r;
	wire chainIn = dataIn[`CHAIN_IN_BIT]; // R7
	wire firstEdge = bitCount_r == 5'h00;

	// chip select high clears the frame and blocks every edge; the
	// word is sampled on the first edge of the frame, whatever the level of busy
	always_ff @(posedge shiftClk or posedge ctlPins.chipSelectN) begin
		if (ctlPins.chipSelectN) begin
			bitCount_r <= 5'h00; // R13
			shiftReg_r <= `RESULT_RESET;
			serialOut_r <= 1'b0;
		end else if (firstEdge) begin
			bitCount_r <= 5'h01;
			serialOut_r <= serialWord_r[15]; // R9
			shiftReg_r <= {serialWord_r[14:0], chainIn}; // R8
		end else begin
			bitCount_r <= (bitCount_r == 5'h1F) ? 5'h1F : bitCount_r + 5'h01;
			serialOut_r <= shiftReg_r[15]; // R9
			shiftReg_r <= {shiftReg_r[14:0], chainIn}; // R8
		end
	end

	// =================================================================
	// outputs
	assign dataOut = {parOut_r[15:11],
		serialSel_r ? serialOut_r : parOut_r[10], parOut_r[9:0]}; // R7
	assign dataOe = oe_r;
	assign busy = busy_r;
	assign sampleHold = hold_r;
	assign poweredDown = pd_r;

	// =================================================================
	// checks
	sequence s_busyFull;
		busy[*8] ##1 busy[*5] ##1 !busy;
	endsequence

	sequence s_startSeen;
		startAccept ##1 (busy && sampleHold);
	endsequence

	a_busy_length: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
		$rose(busy) |-> s_busyFull)
		else $error("busy pulse length wrong");

	a_start_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
		startAccept |-> s_startSeen)
		else $error("start did not hold sample");

	a_start_nocs: assert property (@(posedge sys_clk) disable iff (sys_rst) // R18
		(startFall && !pdActive && state_r == ST_IDLE) |=> busy)
		else $error("start edge lost");

	a_pd_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
		(pdActive && state_r == ST_IDLE) |=> (state_r == ST_IDLE && !busy))
		else $error("start taken while powered down");

	a_reset_float: assert property (@(posedge sys_clk) // R14
		sys_rst |=> (dataOe == 16'h0000 && !busy))
		else $error("reset left drivers on");

	a_oe_gate: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
		(dataOe != 16'h0000) |-> $past(readEnable))
		else $error("drivers on without strobes");

	a_oe_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // R20
		!readEnable |=> dataOe == 16'h0000)
		else $error("drivers on while deselected");

	a_serial_pins: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
		serialMode |=> (dataOe & ~`SERIAL_OE_MASK) == 16'h0000)
		else $error("unused pin driven in serial mode");

	a_par_pins: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
		(!serialMode && readEnable) |=> dataOe == 16'hFFFF)
		else $error("parallel bus not driven");

	a_swap_order: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
		swapOrder |=> parOut_r == {$past(fmtWord[7:0]), $past(fmtWord[15:8])})
		else $error("byte swap wrong");

	a_natural: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
		!swapOrder |=> parOut_r == $past(fmtWord))
		else $error("natural order wrong");

	a_format: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
		1'b1 |=> serialWord_r[15] == ($past(result_r[15]) ^ ~$past(offsetBinary)))
		else $error("code format wrong");

	a_result_latch: assert property (@(posedge sys_clk) disable iff (sys_rst) // R19
		(state_r == ST_CONV && convLast) |=>
		((result_r == $past(sarCode)) && busy) ##1 !busy)
		else $error("result not latched before busy fell");

	a_msb_first: assert property (@(posedge shiftClk) // R9
		disable iff (ctlPins.chipSelectN)
		(bitCount_r == 5'h01) |-> serialOut_r == serialWord_r[15])
		else $error("msb not first");

	a_chain_delay: assert property (@(posedge shiftClk) // R8
		disable iff (ctlPins.chipSelectN)
		(bitCount_r >= `CHAIN_START_COUNT) |-> serialOut_r == $past(chainIn, 17))
		else $error("chain input delay wrong");
endmodule : sar_adc_readout

// >>> test/sar_adc_conversion_and_readout_tb_top.sv
// self-checking bench of the converter control and readout block
// assumes the readout module, its package and the host model
`timescale 1ns/1ps
module sar_adc_conversion_and_readout_tb_top;
	import sar_adc_pkg::*;
	// =================================================================
	// stimulus and observed pins
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	pin_ctl_s ctl; // host control pins
	result_t sarCode; // stand-in comparator code
	logic [15:0] padLevel;
	logic [15:0] dataOut;
	logic [15:0] dataOe;
	logic busy;
	logic sampleHold;
	logic poweredDown;
	logic shiftClk;
	logic chainIn;
	logic [31:0] captured;
	int n_errors = 0;
	int checked = 0;
	always #25 sys_clk = ~sys_clk;
	// pin level from the converter's enables and the chain driver
	assign padLevel = (dataOe & dataOut) |
		(~dataOe & ({15'h0000, chainIn} << 9));
	sar_adc_readout i_sar_adc_readout (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .shiftClk(shiftClk), .ctlPins(ctl),
		.sarCode(sarCode), .dataIn(padLevel), .dataOut(dataOut),
		.dataOe(dataOe), .busy(busy), .sampleHold(sampleHold),
		.poweredDown(poweredDown));
	sar_host_model i_sar_host_model (.shiftClk(shiftClk),
		.chainIn(chainIn), .serialOut(padLevel[10]),
		.captured(captured));
	// =================================================================
	// helpers
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask : tick
	task chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk
	// expected pin word: msb inverted for two's complement, then swap
	function automatic result_t fmtWord(result_t c, logic fmt, logic swp);
		result_t w;
		w = fmt ? c : c ^ 16'h8000;
		return swp ? {w[7:0], w[15:8]} : w;
	endfunction : fmtWord
	task close_out;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	// =================================================================
	// scenarios
	// start edge, count busy and hold cycles; chip select stays high
	task convert(input result_t code);
		int nb;
		int nh;
		nb = 0;
		nh = 0;
		sarCode = code;
		ctl.convertStartN = 1'b0;
		for (int i = 0; i < 8 && busy !== 1'b1; i++) tick(1);
		while (busy === 1'b1 && nb < 40) begin
			nb++;
			if (sampleHold === 1'b1) nh++;
			tick(1);
		end
		chk("ready data", fmtWord(code, 1'b1, 1'b0), dataOut);
		ctl.convertStartN = 1'b1;
		chk("busy cycles", 13, nb);
		chk("hold cycles", 12, nh);
		tick(3);
	endtask : convert
	// every format and swap setting on the parallel bus
	task t_par;
		for (int i = 0; i < 4; i++) begin
			ctl.codeFormatSelect = i[0];
			ctl.byteOrderSwap = i[1];
			ctl.chipSelectN = 1'b0;
			ctl.readN = 1'b0;
			tick(5);
			chk("par oe", 16'hFFFF, dataOe);
			chk("par data", fmtWord(16'hA1C3, i[0], i[1]), dataOut);
			ctl.readN = 1'b1;
			tick(5);
			chk("par oe off", 16'h0000, dataOe);
			ctl.chipSelectN = 1'b1;
			tick(3);
		end
	endtask : t_par
	// clocks while deselected, then a chained serial frame
	task t_ser;
		ctl.interfaceSelect = 1'b1;
		ctl.codeFormatSelect = 1'b0;
		ctl.byteOrderSwap = 1'b1;
		ctl.readN = 1'b0;
		i_sar_host_model.frame(3, 32'hFFFF_FFFF);
		tick(1);
		chk("idle oe", 16'h0000, dataOe);
		ctl.chipSelectN = 1'b0;
		tick(5);
		chk("ser oe", 16'h0400, dataOe);
		i_sar_host_model.frame(20, 32'hB000_0000);
		tick(1);
		chk("ser bits", {12'h000, fmtWord(16'hA1C3, 1'b0, 1'b0), 4'hB},
			captured);
		ctl = 7'h27;
		tick(3);
	endtask : t_ser
	// start edges during power down are dropped
	task t_pd;
		logic seen;
		seen = 1'b0;
		// read the pending result before powering down
		ctl.chipSelectN = 1'b0;
		ctl.readN = 1'b0;
		tick(5);
		chk("pre pd read", 16'hA1C3, padLevel);
		ctl = 7'h27;
		tick(4);
		ctl.powerDownRequest = 1'b1;
		tick(4);
		chk("pd flag", 1, poweredDown);
		ctl.convertStartN = 1'b0;
		repeat (20) begin
			tick(1);
			seen = seen | busy;
		end
		ctl = 7'h27;
		chk("pd busy", 0, seen);
		tick(4);
	endtask : t_pd
	// reset in mid conversion with the bus enabled
	task t_rst;
		ctl.chipSelectN = 1'b0;
		ctl.readN = 1'b0;
		ctl.convertStartN = 1'b0;
		tick(6);
		chk("busy mid", 1, busy);
		sys_rst = 1'b1;
		tick(2);
		chk("rst busy", 0, busy);
		chk("rst oe", 16'h0000, dataOe);
		sys_rst = 1'b0;
		ctl = 7'h27;
		tick(4);
		chk("rst aborted", 0, busy);
	endtask : t_rst
	// =================================================================
	// main sequence; 7'h27: parallel, offset binary, all strobes high
	initial begin
		ctl = 7'h27;
		sarCode = 16'h0000;
		tick(6);
		sys_rst = 1'b0;
		tick(2);
		convert(16'hA1C3);
		t_par();
		t_ser();
		t_pd();
		t_rst();
		close_out();
	end
	// watchdog well beyond the expected run of some 11 us
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule : sar_adc_conversion_and_readout_tb_top

// >>> test/sar_host_model.sv
// host side model: runs the shift clock in frames, feeds the chain pin
// assumes the bench starts a frame only when it wants clocks on the link
`timescale 1ns/1ps
module sar_host_model (
	// link clock and chain pin toward the converter
	output logic shiftClk,
	output logic chainIn,
	// serial result from the converter
	input wire logic serialOut,
	// bits caught in the last frame, newest in bit 0
	output logic [31:0] captured
);
	// =================================================================
	// idle: clock stands still low between frames
	initial begin
		shiftClk = 1'b0;
		chainIn = 1'b0;
		captured = 32'h0000_0000;
	end
	// =================================================================
	// one frame of n clocks at 160 ns, chain bits taken msb first
	task frame(input int n, input logic [31:0] pat);
		captured = 32'h0000_0000;
		#7;
		for (int k = 0; k < n; k++) begin
			chainIn = pat[31 - k];
			#40 shiftClk = 1'b1;
			#80 shiftClk = 1'b0;
			captured = {captured[30:0], serialOut};
			#40;
		end
		// a released chain line must not look like held data
		chainIn = ~chainIn;
	endtask : frame
endmodule : sar_host_model
